// File: rtl/nv_block_pkg.sv
package nv_block_pkg;
  // Array geometry
  localparam int SECTORS = 64;
  localparam int PAGES_PER_SECTOR = 33;
  localparam int BLOCKS_PER_PAGE = 9;
  localparam int NUM_PAGES = SECTORS * PAGES_PER_SECTOR;
  localparam int NUM_BLOCKS = NUM_PAGES * BLOCKS_PER_PAGE;
  localparam int BLOCK_BITS = 128;
  localparam int BLOCK_BYTES = 16;
  localparam int CHK_W = 10;
  localparam int PIDX_W = 11;
  localparam int BIDX_W = 15;
  localparam logic [4:0] SPARE_PAGE = 5'h20;
  localparam logic [3:0] AUX_BLOCK = 4'h8;
  // Address fields
  localparam int SEC_HI = 17;
  localparam int SEC_LO = 12;
  localparam int PG_HI = 11;
  localparam int PG_LO = 7;
  localparam int BLK_HI = 6;
  localparam int BLK_LO = 4;
  localparam int BYTE_HI = 3;
  // Access size codes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  // Status codes
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_SOFT = 2'h1;
  localparam logic [1:0] ST_HARD = 2'h2;
  localparam logic [1:0] ST_ORDER = 2'h3;
  // Page status word fields
  localparam int PS_PROT = 0;
  localparam int PS_USED = 1;
  localparam int PS_MOD = 2;
  localparam int PS_CNT_LO = 16;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int PROG_TIME_NS = 8000000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 21;
  localparam logic [CNT_W-1:0] BLKSW_CYCLES = 21'h000004;
  localparam logic [CNT_W-1:0] LOAD_CYCLES = 21'h000009;
  localparam logic [CNT_W-1:0] READ_CYCLES = 21'h000001;
  localparam logic [CNT_W-1:0] PIPE_EXTRA = 21'h000001;
  // Register map
  localparam logic [7:0] REG_INFO = 8'h00;
  localparam logic [7:0] REG_LIMIT = 8'h04;
  localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [17:0] addr;
    logic [1:0] access_size;
    logic [31:0] write_bus_in;
    logic read_request;
    logic write_request;
    logic program_request;
    logic clear_page_request;
    logic unlock_page_load;
    logic drop_buffer;
    logic sequential_read;
    logic page_info_query;
    logic aux_region_select;
    logic reserve_page_select;
    logic retarget_program;
    logic set_write_lock;
    logic buffer_guard;
    logic extra_output_stage;
  } nv_cmd_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axi_rsp_t;
endpackage : nv_block_pkg

// File: rtl/nv_block.sv
module nv_block #(
  parameter int unsigned PROG_CYCLES_P = nv_block_pkg::PROG_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // User operation port
  input wire nv_block_pkg::nv_cmd_t cmd,
  input wire logic fabric_claim,
  output logic busy,
  output logic [31:0] read_bus_out,
  output logic [1:0] op_status,
  output logic jtag_hold,
  // Register bus
  input wire nv_block_pkg::axi_req_t s_axi_req,
  output nv_block_pkg::axi_rsp_t s_axi_rsp
);
  import nv_block_pkg::*;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_WAIT = 2'b10} fsm_t;
  typedef struct packed {
    logic [BLOCK_BITS-1:0] data;
    logic [1:0] err;
  } ecc_res_t;

  // Nonvolatile array, check bits and per-page bookkeeping
  logic [BLOCK_BITS-1:0] arr_data [0:NUM_BLOCKS-1];
  logic [CHK_W-1:0] arr_chk [0:NUM_BLOCKS-1];
  logic page_prot_ff [0:NUM_PAGES-1];
  logic page_used_ff [0:NUM_PAGES-1];
  logic [15:0] page_cnt_ff [0:NUM_PAGES-1];
  // Page buffer and block buffer pointer
  logic [BLOCK_BITS-1:0] pbuf_ff [0:BLOCKS_PER_PAGE-1];
  logic pb_valid_ff, pb_mod_ff, pb_unlock_ff;
  logic [PIDX_W-1:0] pb_pidx_ff;
  logic [3:0] blk_ff;
  fsm_t state_ff;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [17:0] next_addr_ff;
  logic [31:0] stage_ff, rd_ff;
  logic [1:0] status_ff, nxt_status;
  logic [15:0] limit_ff;
  logic claim_ff;

  // Check code: data bit i carries odd code 2i+3, so no data code collides
  // with a single check-bit flip; top bit is overall parity.
  function automatic logic [CHK_W-1:0] ecc_gen(input logic [BLOCK_BITS-1:0] d);
    logic [CHK_W-2:0] s;
    s = '0;
    for (int i = 0; i < BLOCK_BITS; i++) begin
      if (d[i]) s = s ^ (CHK_W-1)'(2 * i + 3);
    end
    return {^d ^ ^s, s};
  endfunction : ecc_gen

  function automatic ecc_res_t ecc_fix(input logic [BLOCK_BITS-1:0] d, input logic [CHK_W-1:0] c);
    ecc_res_t r;
    logic [CHK_W-1:0] regen;
    logic [CHK_W-2:0] syn;
    logic odd;
    // A function result cannot be part-selected directly, so it is held first
    regen = ecc_gen(d);
    syn = regen[CHK_W-2:0] ^ c[CHK_W-2:0];
    odd = ^d ^ ^c;
    r.data = d;
    r.err = ST_OK;
    if (odd) begin
      r.err = ST_SOFT;
      if (syn[0] && syn >= 9'h003 && syn <= 9'h101) r.data[(int'(syn) - 3) / 2] = ~d[(int'(syn) - 3) / 2];
    end else if (syn != '0) begin
      r.err = ST_HARD;
    end
    return r;
  endfunction : ecc_fix

  // Address decode, read-next continues from the last read
  logic [17:0] eaddr;
  logic [4:0] pg;
  logic [3:0] blk, off;
  logic [2:0] nbytes;
  logic [31:0] size_mask;
  logic [PIDX_W-1:0] pidx;
  logic [BIDX_W-1:0] bidx;
  always_comb begin
    eaddr = (cmd.read_request && cmd.sequential_read) ? next_addr_ff : cmd.addr;
    pg = cmd.reserve_page_select ? SPARE_PAGE : eaddr[PG_HI:PG_LO];
    blk = cmd.aux_region_select ? AUX_BLOCK : {1'b0, eaddr[BLK_HI:BLK_LO]};
    off = cmd.aux_region_select ? {2'h0, eaddr[1:0]} : eaddr[BYTE_HI:0];
    // Size drops the low address bits it covers
    if (cmd.access_size == SIZE_BYTE) begin
      nbytes = 3'h1;
      size_mask = 32'h000000FF;
    end else if (cmd.access_size == SIZE_HALF) begin
      nbytes = 3'h2;
      size_mask = 32'h0000FFFF;
      off[0] = 1'b0;
    end else begin
      nbytes = 3'h4;
      size_mask = 32'hFFFFFFFF;
      off[1:0] = 2'h0;
    end
    pidx = PIDX_W'(eaddr[SEC_HI:SEC_LO]) * PIDX_W'(PAGES_PER_SECTOR) + PIDX_W'(pg);
    bidx = BIDX_W'(pidx) * BIDX_W'(BLOCKS_PER_PAGE) + BIDX_W'(blk);
  end

  // Page and protection checks shared by the decision and the update
  logic in_buf, prot_hit, guard_hit, spare0, over_cnt, any_req;
  assign in_buf = pb_valid_ff && (pb_pidx_ff == pidx);
  assign prot_hit = page_prot_ff[pidx] && !(pb_unlock_ff && in_buf);
  assign guard_hit = cmd.buffer_guard && pb_mod_ff && !in_buf;
  assign spare0 = cmd.reserve_page_select && (eaddr[SEC_HI:SEC_LO] == 6'h00);
  assign over_cnt = page_cnt_ff[pidx] >= limit_ff;
  assign any_req = cmd.read_request | cmd.write_request | cmd.clear_page_request |
                   cmd.program_request | cmd.unlock_page_load | cmd.drop_buffer;

  // Array block read with correction, and whole-page load for the buffer
  ecc_res_t rd_res;
  ecc_res_t ld_res [0:BLOCKS_PER_PAGE-1];
  logic [1:0] ld_err;
  always_comb begin
    rd_res = page_used_ff[pidx] && !spare0 ? ecc_fix(arr_data[bidx], arr_chk[bidx]) : '0;
    ld_err = ST_OK;
    for (int b = 0; b < BLOCKS_PER_PAGE; b++) begin
      ld_res[b] = '0;
      if (page_used_ff[pidx]) begin
        ld_res[b] = ecc_fix(arr_data[BIDX_W'(pidx) * BIDX_W'(BLOCKS_PER_PAGE) + BIDX_W'(b)],
                            arr_chk[BIDX_W'(pidx) * BIDX_W'(BLOCKS_PER_PAGE) + BIDX_W'(b)]);
      end
      if (ld_res[b].err > ld_err) ld_err = ld_res[b].err;
    end
  end

  // Write merge into the target block, read extraction of the output word
  logic [BLOCK_BITS-1:0] wr_src, wr_blk, rd_src;
  logic [31:0] rd_word;
  always_comb begin
    wr_src = in_buf ? pbuf_ff[blk] : ld_res[blk].data;
    wr_blk = wr_src;
    for (int b = 0; b < BLOCK_BYTES; b++) begin
      if (b >= int'(off) && b < int'(off) + int'(nbytes)) begin
        wr_blk[b*8 +: 8] = cmd.write_bus_in[(b - int'(off))*8 +: 8];
      end
    end
    rd_src = in_buf ? pbuf_ff[blk] : rd_res.data;
    rd_word = 32'(rd_src >> {off, 3'h0}) & size_mask;
    if (cmd.page_info_query) begin
      rd_word = '0;
      rd_word[PS_PROT] = page_prot_ff[pidx];
      rd_word[PS_USED] = page_used_ff[pidx];
      rd_word[PS_MOD] = in_buf && pb_mod_ff;
      rd_word[31:PS_CNT_LO] = page_cnt_ff[pidx];
    end
  end

  // Operation decision in priority order: read, write, erase, program, unprotect, discard
  logic [CNT_W-1:0] pipe_add;
  logic do_read, do_write, do_erase, do_prog, do_unprot, do_drop;
  logic wr_ok, pr_ok, er_ok;
  assign pipe_add = cmd.extra_output_stage ? PIPE_EXTRA : '0;
  assign do_read = cmd.read_request;
  assign do_write = !do_read && cmd.write_request;
  assign do_erase = !do_read && !cmd.write_request && cmd.clear_page_request;
  assign do_prog = !do_read && !cmd.write_request && !cmd.clear_page_request && cmd.program_request;
  assign do_unprot = !do_read && !cmd.write_request && !cmd.clear_page_request && !cmd.program_request &&
                     cmd.unlock_page_load;
  assign do_drop = !do_read && !cmd.write_request && !cmd.clear_page_request && !cmd.program_request &&
                   !cmd.unlock_page_load && cmd.drop_buffer;
  assign wr_ok = !spare0 && !prot_hit && !guard_hit;
  // Program needs the buffered page or a retarget, and a change or a new lock
  assign pr_ok = pb_valid_ff && !spare0 && !prot_hit && (cmd.retarget_program || in_buf) &&
                 (pb_mod_ff || cmd.set_write_lock);
  assign er_ok = !spare0 && !prot_hit;

  always_comb begin
    nxt_cnt = '0;
    nxt_status = ST_OK;
    if (do_read) begin
      nxt_cnt = READ_CYCLES + pipe_add;
      nxt_status = (in_buf || cmd.page_info_query) ? ST_OK : rd_res.err;
    end else if (do_write) begin
      if (spare0 || prot_hit) nxt_status = ST_SOFT;
      else if (guard_hit) nxt_status = ST_ORDER;
      else if (!in_buf) nxt_cnt = LOAD_CYCLES;
      else if (blk != blk_ff) nxt_cnt = BLKSW_CYCLES + pipe_add;
    end else if (do_erase) begin
      nxt_cnt = CNT_W'(PROG_CYCLES_P);
      nxt_status = !er_ok ? ST_SOFT : (over_cnt ? ST_ORDER : ST_OK);
    end else if (do_prog) begin
      nxt_cnt = CNT_W'(PROG_CYCLES_P);
      nxt_status = !pr_ok ? ST_SOFT : (over_cnt ? ST_ORDER : ST_OK);
    end else if (do_unprot) begin
      nxt_cnt = LOAD_CYCLES;
      nxt_status = ld_err;
    end
  end

  logic accept;
  assign accept = (state_ff == ST_IDLE) && any_req;

  // Busy sequencer: counts the cycles of the accepted operation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (accept && nxt_cnt != '0) begin
            state_ff <= ST_WAIT;
            cnt_ff <= nxt_cnt;
          end
        end
        ST_WAIT: begin
          cnt_ff <= cnt_ff - 21'h000001;
          if (cnt_ff == 21'h000001) state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
          cnt_ff <= '0;
        end
      endcase
    end
  end
  assign busy = (state_ff == ST_WAIT);

  // Status is sticky: only a newly accepted operation changes it
  always_ff @(posedge aclk) begin
    if (!aresetn) status_ff <= ST_OK;
    else if (accept) status_ff <= nxt_status;
  end
  assign op_status = status_ff;

  // Read path: the stage register loads on each accepted read, the output skips it unless piped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_ff <= '0;
      rd_ff <= '0;
      next_addr_ff <= '0;
    end else begin
      if (accept && do_read) begin
        stage_ff <= rd_word;
        next_addr_ff <= eaddr + 18'(nbytes);
      end
      if (cmd.extra_output_stage) rd_ff <= stage_ff;
      else if (accept && do_read) rd_ff <= rd_word;
    end
  end
  assign read_bus_out = rd_ff;

  // Page buffer: writes land here; array only changes on program or erase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pb_valid_ff <= 1'b0;
      pb_mod_ff <= 1'b0;
      pb_unlock_ff <= 1'b0;
      pb_pidx_ff <= '0;
      blk_ff <= '0;
      for (int b = 0; b < BLOCKS_PER_PAGE; b++) pbuf_ff[b] <= '0;
    end else if (accept) begin
      if (do_write && wr_ok) begin
        if (!in_buf) begin
          for (int b = 0; b < BLOCKS_PER_PAGE; b++) pbuf_ff[b] <= ld_res[b].data;
          pb_pidx_ff <= pidx;
          pb_unlock_ff <= 1'b0;
        end
        pbuf_ff[blk] <= wr_blk;
        blk_ff <= blk;
        pb_valid_ff <= 1'b1;
        pb_mod_ff <= 1'b1;
      end else if (do_prog && pr_ok) begin
        pb_mod_ff <= 1'b0;
        pb_unlock_ff <= 1'b0;
      end else if (do_unprot && !spare0) begin
        for (int b = 0; b < BLOCKS_PER_PAGE; b++) pbuf_ff[b] <= ld_res[b].data;
        pb_pidx_ff <= pidx;
        pb_valid_ff <= 1'b1;
        pb_mod_ff <= 1'b1;
        pb_unlock_ff <= 1'b1;
      end else if (do_drop) begin
        pb_valid_ff <= 1'b0;
        pb_mod_ff <= 1'b0;
        pb_unlock_ff <= 1'b0;
      end
    end
  end

  // Array commit happens at acceptance; busy then covers the array time
  always_ff @(posedge aclk) begin
    if (accept && do_prog && pr_ok) begin
      for (int b = 0; b < BLOCKS_PER_PAGE; b++) begin
        arr_data[BIDX_W'(pidx) * BIDX_W'(BLOCKS_PER_PAGE) + BIDX_W'(b)] <= pbuf_ff[b];
        arr_chk[BIDX_W'(pidx) * BIDX_W'(BLOCKS_PER_PAGE) + BIDX_W'(b)] <= ecc_gen(pbuf_ff[b]);
      end
    end
  end

  // Per-page flags; reset stands in for the erased state of the array
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < NUM_PAGES; p++) begin
        page_prot_ff[p] <= 1'b0;
        page_used_ff[p] <= 1'b0;
        page_cnt_ff[p] <= '0;
      end
    end else if (accept && ((do_prog && pr_ok) || (do_erase && er_ok))) begin
      page_used_ff[pidx] <= do_prog;
      page_prot_ff[pidx] <= do_prog && cmd.set_write_lock;
      page_cnt_ff[pidx] <= page_cnt_ff[pidx] + 16'h0001;
    end
  end

  // Fabric ownership notice toward the JTAG side
  always_ff @(posedge aclk) begin
    if (!aresetn) claim_ff <= 1'b0;
    else claim_ff <= fabric_claim;
  end
  assign jtag_hold = claim_ff;

  // AXI4-Lite slave: address and data taken in either order, one write at a time
  logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  assign s_axi_rsp.awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_rsp.wready = !w_got_ff && !bvalid_ff;
  assign s_axi_rsp.arready = !rvalid_ff;
  assign s_axi_rsp.bvalid = bvalid_ff;
  assign s_axi_rsp.bresp = bresp_ff;
  assign s_axi_rsp.rvalid = rvalid_ff;
  assign s_axi_rsp.rresp = rresp_ff;
  assign s_axi_rsp.rdata = rdata_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      limit_ff <= LIMIT_RESET;
    end else begin
      if (s_axi_req.awvalid && s_axi_rsp.awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_req.awaddr;
      end
      if (s_axi_req.wvalid && s_axi_rsp.wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_req.wdata;
        wstrb_ff <= s_axi_req.wstrb;
      end
      if (aw_got_ff && w_got_ff) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= RESP_OKAY;
        if (awaddr_ff[7:2] == REG_LIMIT[7:2]) begin
          if (wstrb_ff[0]) limit_ff[7:0] <= wdata_ff[7:0];
          if (wstrb_ff[1]) limit_ff[15:8] <= wdata_ff[15:8];
        end else if (awaddr_ff[7:2] != REG_INFO[7:2]) begin
          bresp_ff <= RESP_SLVERR;
        end
      end else if (bvalid_ff && s_axi_req.bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read side: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_req.arvalid && s_axi_rsp.arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      if (s_axi_req.araddr[7:2] == REG_INFO[7:2]) begin
        rdata_ff <= 32'({pb_unlock_ff, pb_mod_ff, pb_valid_ff, busy, status_ff});
      end else if (s_axi_req.araddr[7:2] == REG_LIMIT[7:2]) begin
        rdata_ff <= 32'(limit_ff);
      end else begin
        rdata_ff <= '0;
        rresp_ff <= RESP_SLVERR;
      end
    end else if (rvalid_ff && s_axi_req.rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule : nv_block

// File: verif/nv_block_sva.sv
module nv_block_sva #(
  parameter int unsigned PROG_CYCLES_P = 20
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // User port
  input wire nv_block_pkg::nv_cmd_t cmd,
  input wire logic fabric_claim,
  input wire logic busy,
  input wire logic [31:0] read_bus_out,
  input wire logic [1:0] op_status,
  input wire logic jtag_hold,
  // Register bus
  input wire nv_block_pkg::axi_req_t s_axi_req,
  input wire nv_block_pkg::axi_rsp_t s_axi_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import nv_block_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic hi_req;
  logic acc;
  logic [31:0] busy_run_ff;
  // Accepted strobe, and whether a higher-priority one shadows unprotect or discard
  assign hi_req = cmd.read_request | cmd.write_request | cmd.clear_page_request | cmd.program_request;
  assign acc = !busy && (hi_req | cmd.unlock_page_load | cmd.drop_buffer);
  // Length of the current busy run; program and erase are the longest operations
  always_ff @(posedge aclk) begin
    if (!aresetn || !busy) busy_run_ff <= '0;
    else busy_run_ff <= busy_run_ff + 32'h1;
  end
  a_busy_bounded: assert property (busy_run_ff <= PROG_CYCLES_P)
    else $error("busy held longer than a program");
  a_claim_follow: assert property ($past(aresetn) |-> jtag_hold == $past(fabric_claim))
    else $error("jtag_hold does not follow fabric_claim");
  a_status_sticky: assert property ($past(aresetn) && !$past(acc) |-> $stable(op_status))
    else $error("op_status moved without an accepted request");
  a_read_busy: assert property (acc && cmd.read_request && !cmd.extra_output_stage |=> busy ##1 !busy)
    else $error("plain read busy not one cycle");
  a_read_pipe: assert property (acc && cmd.read_request && cmd.extra_output_stage |=> busy[*2] ##1 !busy)
    else $error("piped read busy not two cycles");
  a_unlock_busy: assert property (acc && !hi_req && cmd.unlock_page_load |=> busy[*8] ##1 busy ##1 !busy)
    else $error("unprotect busy not nine cycles");
  a_drop_idle: assert property (acc && !hi_req && !cmd.unlock_page_load && cmd.drop_buffer |=> !busy)
    else $error("discard raised busy");
  a_data_stands: assert property ($past(aresetn) && !cmd.extra_output_stage && !$past(cmd.extra_output_stage)
    && !$past(acc && cmd.read_request) |-> $stable(read_bus_out))
    else $error("read_bus_out changed without a read");
  a_b_hold: assert property (s_axi_rsp.bvalid && !s_axi_req.bready |=> s_axi_rsp.bvalid)
    else $error("bvalid dropped before bready");
  a_r_answer: assert property (s_axi_req.arvalid && s_axi_rsp.arready |=> s_axi_rsp.rvalid)
    else $error("read address not answered next cycle");
  a_ar_block: assert property (s_axi_rsp.rvalid |-> !s_axi_rsp.arready)
    else $error("arready high while rvalid pending");
  c_program: cover property (acc && cmd.program_request);
  c_order: cover property (op_status == ST_ORDER);
  c_pipe_read: cover property (acc && cmd.read_request && cmd.extra_output_stage);
endmodule : nv_block_sva

bind nv_block nv_block_sva #(.PROG_CYCLES_P(PROG_CYCLES_P)) chk (.aclk(aclk), .aresetn(aresetn), .cmd(cmd),
  .fabric_claim(fabric_claim), .busy(busy), .read_bus_out(read_bus_out), .op_status(op_status),
  .jtag_hold(jtag_hold), .s_axi_req(s_axi_req), .s_axi_rsp(s_axi_rsp));

// File: verif/nv_user_model.sv
module nv_user_model (
  // Clock
  input wire logic aclk,
  // Block handshake
  input wire logic busy,
  output nv_block_pkg::nv_cmd_t cmd,
  output logic fabric_claim
);
  timeunit 1ns;
  timeprecision 1ps;
  import nv_block_pkg::*;
  // Idle until the first request
  initial begin
    cmd = '0;
    fabric_claim = 1'b0;
  end
  // Holds off while busy, offers the request for one cycle, then scrambles
  // address and data so nothing stale can be reused by the block
  task automatic issue(input nv_cmd_t c);
    do begin
      @(posedge aclk);
      #1;
    end while (busy !== 1'b0);
    fabric_claim <= 1'b1;
    cmd <= c;
    @(posedge aclk);
    #1;
    cmd <= '{addr: ~c.addr, write_bus_in: ~c.write_bus_in, extra_output_stage: c.extra_output_stage,
      default: 1'b0};
  endtask : issue
endmodule : nv_user_model

// File: verif/nv_page_block_user_port_test.sv
module nv_page_block_user_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  import nv_block_pkg::*;
  localparam int PROG_N = 20;
  logic aclk;
  logic aresetn;
  nv_cmd_t cmd;
  nv_cmd_t c;
  logic fabric_claim, busy, jtag_hold;
  logic [31:0] read_bus_out, rd;
  logic [1:0] op_status, rs;
  axi_req_t axi_req;
  axi_rsp_t axi_rsp;
  int failures = 0, checks = 0, cycles = 0, n;

  nv_block #(.PROG_CYCLES_P(PROG_N)) dut (.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .fabric_claim(fabric_claim),
    .busy(busy), .read_bus_out(read_bus_out), .op_status(op_status), .jtag_hold(jtag_hold),
    .s_axi_req(axi_req), .s_axi_rsp(axi_rsp));
  nv_user_model user (.aclk(aclk), .busy(busy), .cmd(cmd), .fabric_claim(fabric_claim));

  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Hang guard; the whole run needs a few hundred cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Request of kind k: 0 read, 1 write, 2 erase, 3 program, 4 unprotect, 5 discard
  function automatic nv_cmd_t req(input int k, input logic [17:0] a, input logic [31:0] d = 32'h0);
    req = '0;
    req.addr = a;
    req.write_bus_in = d;
    req.access_size = 2'h2;
    req.read_request = (k == 0);
    req.write_request = (k == 1);
    req.clear_page_request = (k == 2);
    req.program_request = (k == 3);
    req.unlock_page_load = (k == 4);
    req.drop_buffer = (k == 5);
  endfunction : req

  task automatic go(input nv_cmd_t q, input int nb, input logic [1:0] st);
    user.issue(q);
    n = 0;
    while (busy !== 1'b0 && n < 99) begin
      n++;
      @(posedge aclk);
      #1;
    end
    cmp("busy cycles", nb, n);
    cmp("op_status", {30'h0, st}, {30'h0, op_status});
  endtask : go

  task automatic rdv(input nv_cmd_t q, input int nb, input logic [31:0] exp, input logic [31:0] m = '1);
    go(q, nb, ST_OK);
    cmp("read_bus_out", exp, read_bus_out & m);
  endtask : rdv

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (axi_rsp.awready === 1'b1) aw = 1'b0;
      if (axi_rsp.wready === 1'b1) w = 1'b0;
      axi_req.awvalid <= aw;
      axi_req.wvalid <= w;
    end
    while (axi_rsp.bvalid !== 1'b1) @(posedge aclk);
    r = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do @(posedge aclk); while (axi_rsp.arready !== 1'b1);
    axi_req.arvalid <= 1'b0;
    while (axi_rsp.rvalid !== 1'b1) @(posedge aclk);
    d = axi_rsp.rdata;
    r = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask : axi_rd

  task automatic t_idle_regs();
    cmp("busy", 32'h0, {31'h0, busy});
    cmp("op_status", 32'h0, {30'h0, op_status});
    cmp("jtag_hold", 32'h0, {31'h0, jtag_hold});
    axi_rd(REG_LIMIT, rd, rs);
    cmp("limit", {16'h0, LIMIT_RESET}, rd);
    axi_rd(8'h3C, rd, rs);
    cmp("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    // Threshold of one lets a second program of a page report the count
    axi_wr(REG_LIMIT, 32'h00000001, rs);
    axi_rd(REG_LIMIT, rd, rs);
    cmp("limit", 32'h00000001, rd);
  endtask : t_idle_regs

  task automatic t_buffer();
    go(req(1, 18'h00080, 32'h33221100), 9, ST_OK);
    go(req(1, 18'h00084, 32'h77665544), 0, ST_OK);
    go(req(1, 18'h00090, 32'hBBAA9988), 4, ST_OK);
    c = req(1, 18'h000A0, 32'hFFEEDDCC);
    c.extra_output_stage = 1'b1;
    go(c, 5, ST_OK);
    cmp("jtag_hold", 32'h1, {31'h0, jtag_hold});
    c = req(0, 18'h00080);
    c.extra_output_stage = 1'b1;
    rdv(c, 2, 32'h33221100);
    c = req(0, 18'h00081);
    c.access_size = SIZE_BYTE;
    rdv(c, 1, 32'h00000011, 32'h000000FF);
    c.access_size = SIZE_HALF;
    c.addr = 18'h00086;
    rdv(c, 1, 32'h00007766, 32'h0000FFFF);
    rdv(req(0, 18'h00080), 1, 32'h33221100);
    c = req(0, 18'h00000);
    c.sequential_read = 1'b1;
    rdv(c, 1, 32'h77665544);
  endtask : t_buffer

  task automatic t_program();
    c = req(3, 18'h00080);
    c.set_write_lock = 1'b1;
    go(c, PROG_N, ST_OK);
    c.addr = 18'h00100;
    c.retarget_program = 1'b1;
    go(c, PROG_N, ST_OK);
    go(req(5, 18'h00000), 0, ST_OK);
    rdv(req(0, 18'h00104), 1, 32'h77665544);
    c = req(0, 18'h00080);
    c.page_info_query = 1'b1;
    rdv(c, 1, 32'h00010003);
    go(req(1, 18'h00080, 32'h0), 0, ST_SOFT);
  endtask : t_program

  task automatic t_guard_unlock();
    go(req(1, 18'h00200, 32'h5A5A5A5A), 9, ST_OK);
    c = req(1, 18'h00280, 32'h1);
    c.buffer_guard = 1'b1;
    go(c, 0, ST_ORDER);
    go(req(5, 18'h00000), 0, ST_OK);
    go(req(4, 18'h00080), 9, ST_OK);
    go(req(3, 18'h00080), PROG_N, ST_ORDER);
    c = req(0, 18'h00080);
    c.page_info_query = 1'b1;
    rdv(c, 1, 32'h00020002, 32'hFFFFFFFB);
    go(req(2, 18'h00200), PROG_N, ST_OK);
  endtask : t_guard_unlock

  // Reset for four cycles, then the scenarios in order
  initial begin
    aresetn = 1'b0;
    axi_req = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_idle_regs();
    t_buffer();
    t_program();
    t_guard_unlock();
    wrap_up();
  end
endmodule : nv_page_block_user_port_test
